// ### design/stom_consts.svh
/*
 Timing, code and setting constants for the safe torque off monitor.
 Assumes a 200 MHz core clock and inclusion by bare name.
*/
// Summary of operation
// - Both channels closed, no latched fault: drive enabled after a start command, no fault code.
// - Both channels open together: torque off, show code_sto_active.
// - Channel A opens alone: torque off, motor coasts, show code_channel_a_fault.
// - Channel B opens alone: torque off, motor coasts, show code_channel_b_fault.
// - Both channels judged abnormal: show distinct code_dual_channel_fault.
// - Drive output switched off less than 10 ms after trigger.
// - Channel fault indication shown less than 280 ms after trigger.
// - Both-open indication shown less than 100 ms after trigger.
// - Latched channel fault blocks start commands even with channels closed.
// - Channel faults clear only by power cycle, not fault reset.
// - code_sto_active clears by stop reset key, manual or automatic setting.
// - Reset and start while channels open keep torque off.
// - Torque-off state with fault code reached within 20 ms.
// - Safe torque off overrides every command and mode.
`ifndef STOM_CONSTS_SVH
`define STOM_CONSTS_SVH

`define STOM_CLK_MHZ       200
`define STOM_FILT_US       1000
`define STOM_DISC_US       15000
`define STOM_TRIG_MAX_US   10000
`define STOM_IND_CH_US     280000
`define STOM_IND_STO_US    100000
`define STOM_RESP_US       20000
`define STOM_CNT_W         24

`define STOM_CODE_NONE     3'h0
`define STOM_CODE_STO      3'h1
`define STOM_CODE_CH_A     3'h2
`define STOM_CODE_CH_B     3'h3
`define STOM_CODE_DUAL     3'h4

`define STOM_RST_KEY_ONLY  2'h0
`define STOM_RST_MANUAL    2'h1
`define STOM_RST_AUTO      2'h2

`endif

// ### design/stom_pkg.sv
/*
 Types of the safe torque off monitor.
 Assumes stom_consts.svh for the numeric values.
*/
package stom_pkg;
   typedef enum logic [2:0]
   {
      ST_RUN   = 3'b000,
      ST_PEND  = 3'b001,
      ST_STO   = 3'b010,
      ST_FLT_A = 3'b011,
      ST_FLT_B = 3'b100,
      ST_FLT_D = 3'b101
   } stom_state_t;
endpackage

// ### design/stom_monitor.sv
/*
 Dual-channel safe torque off monitor: filters both channel inputs,
 classifies them, gates the power stage and reports a fault code.
 Assumes channel inputs are asynchronous pins, high when the contact is
 closed, and that rst_i is asserted only at power-up of the equipment.
*/
`timescale 1ns/1ps
`include "stom_consts.svh"

module stom_monitor
   import stom_pkg::*;
#(
   parameter int FILT_CYC = `STOM_FILT_US * `STOM_CLK_MHZ,
   parameter int DISC_CYC = `STOM_DISC_US * `STOM_CLK_MHZ
)
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       chan_a_i,
   input  wire logic       chan_b_i,
   input  wire logic       start_cmd_i,
   input  wire logic       stop_cmd_i,
   input  wire logic       stop_reset_key_i,
   input  wire logic       fault_reset_i,
   input  wire logic [1:0] sto_fault_reset_setting_i,
   output logic            drive_enable_o,
   output logic            motor_run_o,
   output logic            torque_off_o,
   output logic [2:0]      fault_code_o
);

   localparam logic [`STOM_CNT_W-1:0] FILT_LAST =
      `STOM_CNT_W'(FILT_CYC - 1);
   localparam logic [`STOM_CNT_W-1:0] DISC_LAST =
      `STOM_CNT_W'(DISC_CYC - 1);

   logic [1:0] pin_raw;
   logic [1:0] closed_f;

   assign pin_raw = {chan_b_i, chan_a_i};

   // Per channel: three-stage synchroniser, then a settle filter
   // Filter restarts on any disagreement, so a short glitch never
   // reaches the classifier; both channels start out as open
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_chan
         logic                  s1_r;
         logic                  s2_r;
         logic                  s3_r;
         logic                  filt_r;
         logic                  filt_nxt;
         logic [`STOM_CNT_W-1:0] cnt_r;
         logic [`STOM_CNT_W-1:0] cnt_nxt;

         always_comb
         begin
            filt_nxt = filt_r;
            cnt_nxt  = '0;
            if ((s2_r == s3_r) && (s3_r != filt_r))
            begin
               if (cnt_r == FILT_LAST)
               begin
                  filt_nxt = s3_r;
               end
               else
               begin
                  cnt_nxt = cnt_r + `STOM_CNT_W'(1);
               end
            end
         end

         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               s1_r   <= 1'b0;
               s2_r   <= 1'b0;
               s3_r   <= 1'b0;
               filt_r <= 1'b0;
               cnt_r  <= '0;
            end
            else
            begin
               s1_r   <= pin_raw[gi];
               s2_r   <= s1_r;
               s3_r   <= s2_r;
               filt_r <= filt_nxt;
               cnt_r  <= cnt_nxt;
            end
         end

         assign closed_f[gi] = filt_r;
      end
   endgenerate

   logic a_open;
   logic b_open;
   logic both_closed;
   logic both_open;
   logic disagree;

   assign a_open      = ~closed_f[0];
   assign b_open      = ~closed_f[1];
   assign both_closed = closed_f[0] & closed_f[1];
   assign both_open   = a_open & b_open;
   assign disagree    = a_open ^ b_open;

   function automatic logic [2:0] code_of(input stom_state_t st);
      case (st)
         ST_STO   : code_of = `STOM_CODE_STO;
         ST_FLT_A : code_of = `STOM_CODE_CH_A;
         ST_FLT_B : code_of = `STOM_CODE_CH_B;
         ST_FLT_D : code_of = `STOM_CODE_DUAL;
         default  : code_of = `STOM_CODE_NONE;
      endcase
   endfunction

   // Discrepancy timer: how long the channels have disagreed
   // A channel fault is only judged once the timer runs out, which
   // gives the second contact time to follow the first one
   logic [`STOM_CNT_W-1:0] disc_r;
   logic [`STOM_CNT_W-1:0] disc_nxt;
   logic                   disc_done;

   assign disc_done = disagree && (disc_r == DISC_LAST);

   always_comb
   begin
      disc_nxt = '0;
      if (disagree && !disc_done)
      begin
         disc_nxt = disc_r + `STOM_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         disc_r <= '0;
      end
      else
      begin
         disc_r <= disc_nxt;
      end
   end

   // Classification and latching of safe torque off conditions
   stom_state_t state_r;
   stom_state_t state_nxt;
   logic        sto_clear;

   // Clear cause for the stop code; channel faults ignore it
   always_comb
   begin
      sto_clear = stop_reset_key_i;
      case (sto_fault_reset_setting_i)
         `STOM_RST_MANUAL : sto_clear = stop_reset_key_i | fault_reset_i;
         `STOM_RST_AUTO   : sto_clear = 1'b1;
         default          : sto_clear = stop_reset_key_i;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN :
         begin
            if (both_open)
            begin
               state_nxt = ST_STO;
            end
            else if (disagree)
            begin
               state_nxt = ST_PEND;
            end
         end
         ST_PEND :
         begin
            if (both_open)
            begin
               state_nxt = ST_STO;
            end
            else if (both_closed)
            begin
               // Contact reclosed inside the window: goes to stop, needs a reset unless the auto setting is chosen
               state_nxt = ST_STO;
            end
            else if (disc_done)
            begin
               state_nxt = a_open ? ST_FLT_A : ST_FLT_B;
            end
         end
         ST_STO :
         begin
            if (disc_done)
            begin
               state_nxt = a_open ? ST_FLT_A : ST_FLT_B;
            end
            else if (both_closed && sto_clear)
            begin
               state_nxt = ST_RUN;
            end
         end
         ST_FLT_A :
         begin
            if (b_open && !both_open)
            begin
               state_nxt = ST_FLT_D;
            end
         end
         ST_FLT_B :
         begin
            if (a_open && !both_open)
            begin
               state_nxt = ST_FLT_D;
            end
         end
         // Dual fault is terminal until power is cycled
         ST_FLT_D :
         begin
            state_nxt = ST_FLT_D;
         end
         default :
         begin
            state_nxt = ST_STO;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      // Power-up comes up in stop so a start needs a clear, deliberate except in the auto setting
      if (rst_i)
      begin
         state_r <= ST_STO;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Run latch and registered outputs
   // All outputs follow the next state, so torque is cut in the same
   // cycle as the state changes and the code never leads the gate
   // The run latch drops on any stop condition; a fresh start is
   // needed after every clear
   logic       run_r;
   logic       run_nxt;
   logic       drv_nxt;
   logic       toff_nxt;
   logic [2:0] code_nxt;
   logic       drv_r;
   logic       toff_r;
   logic [2:0] code_r;

   always_comb
   begin
      run_nxt = run_r;
      if ((state_nxt != ST_RUN) || !both_closed)
      begin
         run_nxt = 1'b0;
      end
      else if (stop_cmd_i)
      begin
         run_nxt = 1'b0;
      end
      else if (start_cmd_i)
      begin
         run_nxt = 1'b1;
      end
      drv_nxt  = run_nxt && (state_nxt == ST_RUN) && both_closed;
      toff_nxt = (state_nxt != ST_RUN) || !both_closed;
      code_nxt = code_of(state_nxt);
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         run_r  <= 1'b0;
         drv_r  <= 1'b0;
         toff_r <= 1'b1;
         code_r <= `STOM_CODE_NONE;
      end
      else
      begin
         run_r  <= run_nxt;
         drv_r  <= drv_nxt;
         toff_r <= toff_nxt;
         code_r <= code_nxt;
      end
   end

   // Straight from the output flip-flops
   assign drive_enable_o = drv_r;
   assign motor_run_o    = run_r;
   assign torque_off_o   = toff_r;
   assign fault_code_o   = code_r;

endmodule // stom_monitor

// ### tb/stom_contact_model.sv
/*
 Model of the two safety contacts that feed the monitor.
 Assumes the bench commands when each contact opens.
*/
`timescale 1ns/1ps
module stom_contact_model
(
   input  wire logic open_a_i,
   input  wire logic open_b_i,
   output logic      chan_a_o,
   output logic      chan_b_o
);
   // Idle contacts stay closed, holding both channels high
   assign chan_a_o = !open_a_i;
   assign chan_b_o = !open_b_i;
endmodule // stom_contact_model

// ### tb/stom_monitor_sva.sv
/*
 Port checker for the safe torque off monitor.
 Assumes FILT_CYC equals the value given to the bound monitor.
*/
`timescale 1ns/1ps
module stom_monitor_sva
#(
   parameter int FILT_CYC = 8
)
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       chan_a_i,
   input wire logic       chan_b_i,
   input wire logic       start_cmd_i,
   input wire logic       stop_cmd_i,
   input wire logic       stop_reset_key_i,
   input wire logic       fault_reset_i,
   input wire logic [1:0] sto_fault_reset_setting_i,
   input wire logic       drive_enable_o,
   input wire logic       motor_run_o,
   input wire logic       torque_off_o,
   input wire logic [2:0] fault_code_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   int open_r;
   int open_nxt;
   // Cycles during which at least one channel has been open
   always_comb
   begin
      open_nxt = (chan_a_i && chan_b_i) ? 0 : open_r + 1;
   end
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         open_r <= 0;
      else
         open_r <= open_nxt;
   end
   drive_ok_a: assert property (drive_enable_o |-> !torque_off_o && fault_code_o == 3'h0)
      else $error("drive enabled while off or faulted");
   fault_off_a: assert property (fault_code_o != 3'h0 |-> torque_off_o && !drive_enable_o)
      else $error("fault code shown with torque on");
   run_gate_a: assert property (motor_run_o |-> drive_enable_o)
      else $error("motor running without drive");
   open_off_a: assert property (open_r > FILT_CYC + 6 |-> torque_off_o)
      else $error("torque not cut after channel opened");
   start_src_a: assert property ($rose(motor_run_o) |-> $past(start_cmd_i) && !$past(stop_cmd_i))
      else $error("motor started without start command");
   stop_wins_a: assert property (stop_cmd_i |=> !motor_run_o)
      else $error("motor still running after stop");
   code_latch_a: assert property ($past(fault_code_o) >= 3'h2 |->
      fault_code_o == $past(fault_code_o) || fault_code_o == 3'h4)
      else $error("channel fault code left its latch");
   sto_clear_a: assert property ($past(fault_code_o) == 3'h1 && fault_code_o == 3'h0 |->
      $past(stop_reset_key_i) || $past(stop_reset_key_i, 2) || sto_fault_reset_setting_i == 2'h2
      || (sto_fault_reset_setting_i == 2'h1 && ($past(fault_reset_i) || $past(fault_reset_i, 2))))
      else $error("stop code cleared without reset cause");
endmodule // stom_monitor_sva

bind stom_monitor stom_monitor_sva #(.FILT_CYC(FILT_CYC)) u_sva (.*);

// ### tb/stom_monitor_test.sv
/*
 Self-checking bench for the safe torque off monitor.
 Assumes short filter counts and the contact model on both channels.
*/
`timescale 1ns/1ps
`include "stom_consts.svh"
module stom_monitor_test;
   localparam int FC = 8;
   logic       clk   = 1'b0;
   logic       rst   = 1'b1;
   logic       opa   = 1'b0;
   logic       opb   = 1'b0;
   logic       start = 1'b0;
   logic       stop  = 1'b0;
   logic       key   = 1'b0;
   logic       frst  = 1'b0;
   logic [1:0] sett  = 2'h0;
   logic       cha;
   logic       chb;
   logic       drv;
   logic       run;
   logic       toff;
   logic [2:0] code;
   int         bad_count = 0;
   int         samples_checked = 0;
   // Open A, open B, code expected
   logic [4:0] rows [3] = '{{2'b11, `STOM_CODE_STO}, {2'b10, `STOM_CODE_CH_A},
                            {2'b01, `STOM_CODE_CH_B}};

   stom_contact_model SW (.open_a_i(opa), .open_b_i(opb), .chan_a_o(cha), .chan_b_o(chb));
   stom_monitor #(.FILT_CYC(FC), .DISC_CYC(40)) DUT (.core_clk_i(clk), .rst_i(rst),
      .chan_a_i(cha), .chan_b_i(chb), .start_cmd_i(start), .stop_cmd_i(stop),
      .stop_reset_key_i(key), .fault_reset_i(frst), .sto_fault_reset_setting_i(sett),
      .drive_enable_o(drv), .motor_run_o(run), .torque_off_o(toff), .fault_code_o(code));

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cmp(string what, logic [2:0] exp, logic [2:0] got);
      samples_checked++;
      if (exp !== got)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_code(logic [2:0] exp);
      int n;
      n = 0;
      while (code !== exp && n < 200)
      begin
         tick(1);
         n++;
      end
      if (code !== exp)
      begin
         cmp("code wait", exp, code);
         conclude();
      end
   endtask

   task automatic power_up(logic [1:0] s);
      rst = 1'b1;
      opa = 1'b0;
      opb = 1'b0;
      sett = s;
      tick(6);
      cmp("reset outputs", 3'b001, {drv, run, toff});
      rst = 1'b0;
      wait_code(`STOM_CODE_STO);
      tick(FC + 8);
      key = (s != `STOM_RST_AUTO);
      tick(3);
      key = 1'b0;
      wait_code(`STOM_CODE_NONE);
   endtask

   task automatic go();
      start = 1'b1;
      tick(1);
      start = 1'b0;
   endtask

   initial
   begin
      for (int i = 0; i < 3; i++)
      begin
         power_up(`STOM_RST_KEY_ONLY);
         go();
         cmp("running", 3'b110, {drv, run, toff});
         opa = rows[i][4];
         opb = rows[i][3];
         tick(FC + 9);
         cmp("torque off", 3'b001, {drv, run, toff});
         wait_code(rows[i][2:0]);
         frst = 1'b1;
         go();
         tick(2);
         frst = 1'b0;
         cmp("reset while open", 3'b001, {drv, run, toff});
         opa = 1'b0;
         opb = 1'b0;
         tick(FC + 8);
         key = 1'b1;
         tick(3);
         key = 1'b0;
         tick(3);
         go();
         cmp("code after key", (i == 0) ? 3'h0 : rows[i][2:0], code);
         cmp("restart", (i == 0) ? 3'b110 : 3'b001, {drv, run, toff});
      end
      power_up(`STOM_RST_KEY_ONLY);
      opa = 1'b1;
      wait_code(`STOM_CODE_CH_A);
      opa = 1'b0;
      tick(20);
      opb = 1'b1;
      wait_code(`STOM_CODE_DUAL);
      power_up(`STOM_RST_MANUAL);
      go();
      opb = 1'b1;
      tick(2);
      opb = 1'b0;
      tick(FC + 10);
      cmp("glitch ignored", 3'b110, {drv, run, toff});
      start = 1'b1;
      stop = 1'b1;
      tick(1);
      start = 1'b0;
      stop = 1'b0;
      cmp("stop wins", 3'h0, {2'b00, run});
      opa = 1'b1;
      opb = 1'b1;
      wait_code(`STOM_CODE_STO);
      opa = 1'b0;
      opb = 1'b0;
      tick(FC + 8);
      frst = 1'b1;
      tick(3);
      frst = 1'b0;
      tick(3);
      cmp("manual clear", 3'h0, code);
      power_up(`STOM_RST_AUTO);
      go();
      cmp("auto running", 3'b110, {drv, run, toff});
      conclude();
   end
endmodule // stom_monitor_test
